// >>> verilog/oad_pkg.sv
package oad_pkg;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FR_W       = 9;
  localparam int FR_MODE    = 8;
  localparam int FR_BASE    = 7;
  localparam int OFS_W      = 7;
  localparam int PTR_W      = 12;
  localparam int TGT_W      = 13;
  localparam int PAGE_W     = 3;
  localparam int OP2_LSB    = 10;
  localparam int D_BIT      = 9;
  localparam int IMM_LSB    = 8;
  localparam int JMP_LSB    = 13;
  localparam int BOP_LSB    = 12;
  localparam int BSEL_LSB   = 9;

  // ----------------------------------------
  // Address constants and reset values
  // ----------------------------------------
  localparam logic [11:0] GLOBAL_BASE = 12'h080;
  localparam logic [15:0] DP_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h0fff;
  localparam logic [15:0] PTR_ONE     = 16'h0001;

  // ----------------------------------------
  // Format class codes (arbitrary encodings)
  // ----------------------------------------
  localparam logic [6:0] MISC_TAG  = 7'h00;
  localparam logic [2:0] JMP_OPC   = 3'h7;
  localparam logic [2:0] CALL_OPC  = 3'h6;
  localparam logic [1:0] BOP_TAG   = 2'h2;
  localparam logic [3:0] IMM_TAG   = 4'h7;

  // ----------------------------------------
  // Opcodes (arbitrary encodings)
  // ----------------------------------------
  localparam logic [5:0] OPC_MUL    = 6'h05;
  localparam logic [5:0] OPC_MULS   = 6'h06;
  localparam logic [5:0] OPC_CLRCMP = 6'h07;
  localparam logic [5:0] OPC_PUSH   = 6'h08;
  localparam logic [5:0] OPC_POP    = 6'h09;
  localparam logic [7:0] OPC_LOADH  = 8'h70;
  localparam logic [7:0] OPC_LOADL  = 8'h71;
  localparam logic [7:0] OPC_PUSHL  = 8'h72;

  typedef enum {
    FMT_TWO_OP, FMT_IMM, FMT_JUMP, FMT_BIT, FMT_MISC
  } oad_format_t;

  typedef enum {
    EA_INDIRECT, EA_DIRECT_SPECIAL, EA_DIRECT_GLOBAL, EA_OFFSET_DP, EA_OFFSET_SP
  } oad_ea_mode_t;

  typedef struct packed {
    logic                     valid;
    oad_format_t              fmt;
    logic [8:0]               opcode;
    logic                     dest_sel;
    logic [FR_W-1:0]          operand_address_field;
    logic [2:0]               bit_select;
    logic [7:0]               immediate_literal_field;
    logic [15:0]              jump_target;
    oad_ea_mode_t             ea_mode;
    logic [PTR_W-1:0]         ea;
    logic [PTR_W-1:0]         stack_ea;
    logic                     rd_mem;
    logic                     wr_w;
    logic                     wr_mem;
    logic                     wr_multiply_high_register;
    logic                     wr_stack;
    logic                     is_push;
    logic                     is_pop;
  } oad_dec_t;

endpackage

// >>> verilog/oad_ea_calc.sv
`timescale 1ns/10ps
module oad_ea_calc
  import oad_pkg::*;
(
  input  wire logic [oad_pkg::FR_W-1:0]  operand_address_field,
  input  wire logic [15:0]               ip,
  input  wire logic [15:0]               dp,
  input  wire logic [15:0]               sp,
  output oad_pkg::oad_ea_mode_t          ea_mode,
  output logic [oad_pkg::PTR_W-1:0]      ea
);
  import oad_pkg::*;

  logic [PTR_W-1:0] base;
  logic [PTR_W-1:0] ofs;

  // Base from pointer
  // Upper pointer nibble never reaches the sum
  assign base = operand_address_field[FR_BASE] ? sp[PTR_W-1:0] : dp[PTR_W-1:0];
  assign ofs  = {{(PTR_W-OFS_W){1'b0}}, operand_address_field[OFS_W-1:0]};

  always_comb begin
    if (operand_address_field[FR_MODE]) begin
      ea_mode = operand_address_field[FR_BASE] ? EA_OFFSET_SP : EA_OFFSET_DP;
      ea      = base + ofs;
    end else if (operand_address_field == '0) begin
      ea_mode = EA_INDIRECT;
      ea      = ip[PTR_W-1:0];
    end else if (operand_address_field[FR_BASE]) begin
      ea_mode = EA_DIRECT_GLOBAL;
      ea      = GLOBAL_BASE + ofs;
    end else begin
      ea_mode = EA_DIRECT_SPECIAL;
      ea      = ofs;
    end
  end

endmodule

// >>> verilog/oad_decoder.sv
`timescale 1ns/10ps
module oad_decoder
  import oad_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          instr_valid,
  input  wire logic [15:0]                   instr,
  input  wire logic [oad_pkg::PAGE_W-1:0]    page_select_bits,
  input  wire logic [15:0]                   ip,
  output oad_pkg::oad_dec_t                  dec,
  output logic [7:0]                         data_pointer_high,
  output logic [7:0]                         data_pointer_low,
  output logic [7:0]                         stack_pointer_high,
  output logic [7:0]                         stack_pointer_low
);
  import oad_pkg::*;

  // ----------------------------------------
  // Pointer state
  // ----------------------------------------
  logic [15:0]      dp;
  logic [15:0]      sp;
  oad_ea_mode_t     ea_mode;
  logic [PTR_W-1:0] ea;
  oad_dec_t         next_dec;
  oad_format_t      fmt;
  logic [5:0]       op2;
  logic [7:0]       opi;
  logic             d;
  logic             is_mul;
  logic             is_push;
  logic             is_pop;
  logic             is_loadh;
  logic             is_loadl;

  assign data_pointer_high  = dp[15:8];
  assign data_pointer_low   = dp[7:0];
  assign stack_pointer_high = sp[15:8];
  assign stack_pointer_low  = sp[7:0];

  // ----------------------------------------
  // Format classification
  // ----------------------------------------
  function automatic oad_format_t classify(input logic [15:0] w);
    oad_format_t f;
    f = FMT_TWO_OP;
    if (w[15:D_BIT] == MISC_TAG)
      f = FMT_MISC;
    else if (w[15:JMP_LSB] == JMP_OPC || w[15:JMP_LSB] == CALL_OPC)
      f = FMT_JUMP;
    else if (w[15:14] == BOP_TAG)
      f = FMT_BIT;
    else if (w[15:BOP_LSB] == IMM_TAG)
      f = FMT_IMM;
    return f;
  endfunction

  assign fmt      = classify(instr);
  assign op2      = instr[15:OP2_LSB];
  assign opi      = instr[15:IMM_LSB];
  assign d        = instr[D_BIT];
  assign is_mul   = fmt == FMT_TWO_OP && (op2 == OPC_MUL || op2 == OPC_MULS);
  assign is_push  = fmt == FMT_TWO_OP && op2 == OPC_PUSH;
  assign is_pop   = fmt == FMT_TWO_OP && op2 == OPC_POP;
  assign is_loadh = fmt == FMT_IMM && opi == OPC_LOADH;
  assign is_loadl = fmt == FMT_IMM && opi == OPC_LOADL;

  // ----------------------------------------
  // Effective address
  // ----------------------------------------
  // Address formed from field
  oad_ea_calc u_ea (
    .operand_address_field (instr[FR_W-1:0]),
    .ip                    (ip),
    .dp                    (dp),
    .sp                    (sp),
    .ea_mode               (ea_mode),
    .ea                    (ea)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    next_dec                         = '0;
    next_dec.valid                   = instr_valid;
    next_dec.fmt                     = fmt;
    next_dec.ea_mode                 = ea_mode;
    // Operand address from pointer before update
    next_dec.ea                      = ea;
    next_dec.immediate_literal_field = instr[7:0];
    next_dec.jump_target             = {page_select_bits, instr[TGT_W-1:0]};
    case (fmt)
      FMT_TWO_OP: begin
        next_dec.opcode                = {3'h0, op2};
        next_dec.dest_sel              = d;
        next_dec.operand_address_field = instr[FR_W-1:0];
        next_dec.rd_mem                = 1'b1;
        if (is_mul) begin
          next_dec.wr_w    = 1'b1;
          next_dec.wr_multiply_high_register = 1'b1;
        end else if (op2 == OPC_CLRCMP) begin
          next_dec.rd_mem = d;
          next_dec.wr_mem = ~d;
        end else if (is_push) begin
          next_dec.wr_stack = 1'b1;
          next_dec.is_push  = 1'b1;
          next_dec.stack_ea = sp[PTR_W-1:0];
        end else if (is_pop) begin
          next_dec.rd_mem   = 1'b0;
          next_dec.wr_mem   = 1'b1;
          next_dec.is_pop   = 1'b1;
          next_dec.stack_ea = sp[PTR_W-1:0] + PTR_ONE[PTR_W-1:0];
        end else begin
          next_dec.wr_w   = ~d;
          next_dec.wr_mem = d;
        end
      end
      FMT_IMM: begin
        next_dec.opcode = {1'b0, opi};
        if (opi == OPC_PUSHL) begin
          next_dec.wr_stack = 1'b1;
          next_dec.is_push  = 1'b1;
          next_dec.stack_ea = sp[PTR_W-1:0];
        end else if (!is_loadh && !is_loadl) begin
          next_dec.wr_w = 1'b1;
        end
      end
      FMT_JUMP: begin
        next_dec.opcode = {6'h00, instr[15:JMP_LSB]};
      end
      FMT_BIT: begin
        next_dec.opcode                = {5'h00, instr[15:BOP_LSB]};
        next_dec.bit_select            = instr[11:BSEL_LSB];
        next_dec.operand_address_field = instr[FR_W-1:0];
        next_dec.rd_mem                = 1'b1;
        next_dec.wr_mem                = 1'b1;
      end
      FMT_MISC: begin
        next_dec.opcode = instr[FR_W-1:0];
      end
      default: begin
        next_dec.valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Registered decode, one word per cycle
  // ----------------------------------------
  // Single word, every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec <= '0;
    end else begin
      dec <= next_dec;
    end
  end

  // ----------------------------------------
  // Data pointer
  // ----------------------------------------
  // Byte loads of the data pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp <= DP_RESET;
    end else if (instr_valid && is_loadh) begin
      dp[15:8] <= instr[7:0];
    end else if (instr_valid && is_loadl) begin
      dp[7:0] <= instr[7:0];
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  // Post-decrement push, pre-increment pop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp <= SP_RESET;
    end else if (instr_valid && next_dec.is_push) begin
      sp <= sp - PTR_ONE;
    end else if (instr_valid && is_pop) begin
      sp <= sp + PTR_ONE;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [PTR_W-1:0] dp_sum;
  logic [PTR_W-1:0] sp_sum;
  assign dp_sum = dp[PTR_W-1:0] + {5'h00, instr[OFS_W-1:0]};
  assign sp_sum = sp[PTR_W-1:0] + {5'h00, instr[OFS_W-1:0]};

  property p_offset_dp;
    @(posedge clk) disable iff (!rst_n)
      (instr[8:7] == 2'b10) |=> dec.ea == $past(dp_sum) && dec.ea_mode == EA_OFFSET_DP;
  endproperty
  a_offset_dp: assert property (p_offset_dp) else $error("dp offset address wrong");

  property p_offset_sp;
    @(posedge clk) disable iff (!rst_n)
      (instr[8:7] == 2'b11) |=> dec.ea == $past(sp_sum) && dec.ea_mode == EA_OFFSET_SP;
  endproperty
  a_offset_sp: assert property (p_offset_sp) else $error("sp offset address wrong");

  property p_pop_timing;
    @(posedge clk) disable iff (!rst_n)
      (instr_valid && is_pop) |=> sp == $past(sp) + PTR_ONE
        && dec.stack_ea == sp[PTR_W-1:0] && dec.is_pop;
  endproperty
  a_pop_timing: assert property (p_pop_timing) else $error("pop pointer wrong");

  property p_push;
    @(posedge clk) disable iff (!rst_n)
      (instr_valid && is_push) |=> sp == $past(sp) - PTR_ONE
        && dec.stack_ea == $past(sp[PTR_W-1:0]);
  endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");

  property p_loadh;
    @(posedge clk) disable iff (!rst_n)
      (instr_valid && is_loadh) |=> data_pointer_high == $past(instr[7:0])
        && data_pointer_low == $past(dp[7:0]);
  endproperty
  a_loadh: assert property (p_loadh) else $error("loadh wrong");

  property p_indirect;
    @(posedge clk) disable iff (!rst_n)
      (instr[FR_W-1:0] == '0) |=> dec.ea == $past(ip[PTR_W-1:0]);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");

  property p_global;
    @(posedge clk) disable iff (!rst_n)
      (instr[8:7] == 2'b01) |=> dec.ea == GLOBAL_BASE + {5'h00, $past(instr[6:0])};
  endproperty
  a_global: assert property (p_global) else $error("global address wrong");

  property p_mul;
    @(posedge clk) disable iff (!rst_n)
      is_mul |=> dec.wr_w && dec.wr_multiply_high_register && !dec.wr_mem;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply destination wrong");

  property p_dest;
    @(posedge clk) disable iff (!rst_n)
      (fmt == FMT_TWO_OP && !is_mul && !is_push && !is_pop && op2 != OPC_CLRCMP)
        |=> dec.wr_mem == $past(d) && dec.wr_w == !$past(d);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_jump;
    @(posedge clk) disable iff (!rst_n)
      fmt == FMT_JUMP |=> dec.jump_target == {$past(page_select_bits), $past(instr[12:0])};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_misc;
    @(posedge clk) disable iff (!rst_n)
      (instr[15:9] == MISC_TAG) |=> dec.fmt == FMT_MISC && dec.opcode == $past(instr[8:0]);
  endproperty
  a_misc: assert property (p_misc) else $error("misc decode wrong");

  property p_rate;
    @(posedge clk) disable iff (!rst_n)
      instr_valid [*2] |=> dec.valid;
  endproperty
  a_rate: assert property (p_rate) else $error("decode stalled");

  property p_call_sp;
    @(posedge clk) disable iff (!rst_n)
      fmt == FMT_JUMP |=> $stable(sp);
  endproperty
  a_call_sp: assert property (p_call_sp) else $error("call moved stack");

  property p_loadl;
    @(posedge clk) disable iff (!rst_n)
      (instr_valid && is_loadl) |=> data_pointer_low == $past(instr[IMM_LSB-1:0])
        && data_pointer_high == $past(dp[15:IMM_LSB]);
  endproperty
  a_loadl: assert property (p_loadl) else $error("loadl wrong");

  property p_bitop;
    @(posedge clk) disable iff (!rst_n)
      fmt == FMT_BIT |=> dec.bit_select == $past(instr[BOP_LSB-1:BSEL_LSB])
        && dec.operand_address_field == $past(instr[FR_W-1:0]);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit operation fields wrong");

  property p_imm;
    @(posedge clk) disable iff (!rst_n)
      fmt == FMT_IMM |=> dec.immediate_literal_field == $past(instr[IMM_LSB-1:0])
        && dec.opcode == {1'b0, $past(instr[15:IMM_LSB])};
  endproperty
  a_imm: assert property (p_imm) else $error("immediate fields wrong");

  property p_clrcmp;
    @(posedge clk) disable iff (!rst_n)
      (fmt == FMT_TWO_OP && op2 == OPC_CLRCMP)
        |=> dec.rd_mem == $past(d) && dec.wr_mem == !$past(d) && !dec.wr_w;
  endproperty
  a_clrcmp: assert property (p_clrcmp) else $error("clear or compare wrong");

  property p_pushl;
    @(posedge clk) disable iff (!rst_n)
      (instr_valid && fmt == FMT_IMM && opi == OPC_PUSHL)
        |=> sp == $past(sp) - PTR_ONE && dec.wr_stack
        && dec.stack_ea == $past(sp[PTR_W-1:0]);
  endproperty
  a_pushl: assert property (p_pushl) else $error("literal push wrong");

  c_offset_dp: cover property (@(posedge clk) instr_valid && instr[8:7] == 2'b10);
  c_pop_sp:    cover property (@(posedge clk) instr_valid && is_pop && instr[8:7] == 2'b11);
  c_loadh_use: cover property (@(posedge clk) instr_valid && is_loadh ##1 instr_valid
                               && instr[8:7] == 2'b10);
  c_jump:      cover property (@(posedge clk) instr_valid && fmt == FMT_JUMP);
  c_misc:      cover property (@(posedge clk) instr_valid && fmt == FMT_MISC);

endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import oad_pkg::*;

  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic                clk;
  logic                rst_n;
  logic                instr_valid;
  logic [15:0]         instr;
  logic [PAGE_W-1:0]   page_select_bits;
  logic [15:0]         ip;
  oad_dec_t            dec;
  logic [7:0]          data_pointer_high;
  logic [7:0]          data_pointer_low;
  logic [7:0]          stack_pointer_high;
  logic [7:0]          stack_pointer_low;
  int                  fail_count;
  int                  cmp_count;

  oad_decoder dut_u (
    .clk                (clk),
    .rst_n              (rst_n),
    .instr_valid        (instr_valid),
    .instr              (instr),
    .page_select_bits   (page_select_bits),
    .ip                 (ip),
    .dec                (dec),
    .data_pointer_high  (data_pointer_high),
    .data_pointer_low   (data_pointer_low),
    .stack_pointer_high (stack_pointer_high),
    .stack_pointer_low  (stack_pointer_low)
  );

  always #25 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] two_op(logic [5:0] op, logic d, logic [8:0] fr);
    return {op, d, fr};
  endfunction

  // Entered at a falling edge; decode is visible at the next one
  task automatic step(input logic [15:0] word, input logic vld = 1'b1);
    instr       = word;
    instr_valid = vld;
    @(negedge clk);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_dp_offset(input logic [7:0] hi, input logic [7:0] lo,
                             input logic [6:0] ofs, input logic [11:0] exp);
    step({OPC_LOADH, hi});
    chk({8'h00, data_pointer_high}, {8'h00, hi});
    step({OPC_LOADL, lo});
    chk({data_pointer_high, data_pointer_low}, {hi, lo});
    // Offset use right after the load, no gap cycle
    step(two_op(6'h01, 1'b0, {2'b10, ofs}));
    chk(16'(dec.ea_mode), 16'(EA_OFFSET_DP));
    chk({4'h0, dec.ea}, {4'h0, exp});
  endtask

  task automatic t_stack;
    step(two_op(6'h01, 1'b0, 9'h185));
    chk(16'(dec.ea_mode), 16'(EA_OFFSET_SP));
    chk({4'h0, dec.ea}, 16'h0004);
    step(two_op(OPC_PUSH, 1'b0, 9'h0c5));
    chk({14'h0, dec.is_push, dec.wr_stack}, 16'h0003);
    chk({4'h0, dec.stack_ea}, 16'h0fff);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0ffe);
    step({OPC_PUSHL, 8'h33});
    chk({15'h0, dec.wr_stack}, 16'h0001);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0ffd);
    // Pop through an sp offset: operand from old sp, stack byte from new
    step(two_op(OPC_POP, 1'b0, 9'h182));
    chk({14'h0, dec.is_pop, dec.wr_mem}, 16'h0003);
    chk({4'h0, dec.ea}, 16'h0fff);
    chk({4'h0, dec.stack_ea}, 16'h0ffe);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0ffe);
    // Not valid: pointer must hold
    step(two_op(OPC_POP, 1'b0, 9'h180), 1'b0);
    chk({15'h0, dec.valid}, 16'h0000);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0ffe);
    step(two_op(OPC_POP, 1'b0, 9'h180));
    chk({4'h0, dec.ea}, 16'h0ffe);
    chk({4'h0, dec.stack_ea}, 16'h0fff);
    // Call leaves the data stack alone
    step({CALL_OPC, 13'h0100});
    chk({stack_pointer_high, stack_pointer_low}, 16'h0fff);
    // Pop past the top: pointer carries into the unused nibble
    step(two_op(OPC_POP, 1'b0, 9'h181));
    chk({4'h0, dec.ea}, 16'h0000);
    chk({stack_pointer_high, stack_pointer_low}, 16'h1000);
    step(two_op(6'h01, 1'b0, 9'h185));
    chk({4'h0, dec.ea}, 16'h0005);
  endtask

  task automatic t_modes;
    logic [8:0]   frs[3];
    oad_ea_mode_t modes[3];
    logic [11:0]  eas[3];
    frs   = '{9'h000, 9'h012, 9'h0c5};
    modes = '{EA_INDIRECT, EA_DIRECT_SPECIAL, EA_DIRECT_GLOBAL};
    eas   = '{12'h385, 12'h012, 12'h0c5};
    for (int i = 0; i < 3; i++) begin
      step(two_op(6'h01, 1'b0, frs[i]));
      chk(16'(dec.ea_mode), 16'(modes[i]));
      chk({4'h0, dec.ea}, {4'h0, eas[i]});
    end
  endtask

  task automatic t_formats;
    page_select_bits = 3'h5;
    step({6'h13, 1'b1, 9'h0c5});
    chk(16'(dec.fmt), 16'(FMT_TWO_OP));
    chk({6'h0, dec.opcode, dec.dest_sel}, {7'h0, 8'h13, 1'b1});
    chk({7'h0, dec.operand_address_field}, 16'h00c5);
    step({8'h7d, 8'h5a});
    chk(16'(dec.fmt), 16'(FMT_IMM));
    chk({7'h0, dec.opcode}, 16'h007d);
    chk({7'h0, dec.wr_w, dec.immediate_literal_field}, 16'h015a);
    step({JMP_OPC, 13'h1abc});
    chk(16'(dec.fmt), 16'(FMT_JUMP));
    chk({7'h0, dec.opcode}, 16'h0007);
    chk(dec.jump_target, 16'hbabc);
    step({4'ha, 3'h5, 9'h0c5});
    chk(16'(dec.fmt), 16'(FMT_BIT));
    chk({4'h0, dec.opcode, dec.bit_select}, {7'h0, 6'h0a, 3'h5});
    chk({7'h0, dec.operand_address_field}, 16'h00c5);
    step(16'h0123);
    chk(16'(dec.fmt), 16'(FMT_MISC));
    chk({7'h0, dec.opcode}, 16'h0123);
  endtask

  task automatic t_dest;
    logic [5:0] ops[7];
    logic       ds[7];
    logic [3:0] exps[7];
    ops  = '{6'h01, 6'h01, OPC_MUL, OPC_MUL, OPC_MULS, OPC_CLRCMP, OPC_CLRCMP};
    ds   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    // Flags: rd_mem, wr_w, wr_mem, wr_multiply_high_register
    exps = '{4'hc, 4'ha, 4'hd, 4'hd, 4'hd, 4'h2, 4'h8};
    for (int i = 0; i < 7; i++) begin
      step(two_op(ops[i], ds[i], 9'h0c5));
      chk({12'h0, dec.rd_mem, dec.wr_w, dec.wr_mem, dec.wr_multiply_high_register},
          {12'h0, exps[i]});
    end
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    clk              = 1'b0;
    rst_n            = 1'b0;
    instr_valid      = 1'b0;
    instr            = 16'h0000;
    page_select_bits = 3'h0;
    ip               = 16'hf385;
    fail_count       = 0;
    cmp_count        = 0;
    repeat (12) @(negedge clk);
    chk({15'h0, dec === '0}, 16'h0001);
    chk({data_pointer_high, data_pointer_low}, DP_RESET);
    chk({stack_pointer_high, stack_pointer_low}, SP_RESET);
    rst_n = 1'b1;
    t_dp_offset(8'h03, 8'h85, 7'h08, 12'h38d);
    t_dp_offset(8'hff, 8'hc0, 7'h7f, 12'h03f);
    t_stack();
    t_modes();
    t_formats();
    t_dest();
    step(16'h0000, 1'b0);
    finish_test();
  end

  // Decode latency is fixed, so a hang means a stuck bench
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    finish_test();
  end

endmodule
